// [logic/wdog_pkg.sv]
// Purpose: shared constants for the software watchdog block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: offsets are byte addresses
package wdog_pkg;
  // ==========================================================
  // register map
  localparam logic [11:0] ADDR_ENABLE_ZERO = 12'h000;
  localparam logic [11:0] ADDR_ENABLE_ONE = 12'h004;
  localparam logic [11:0] ADDR_PRIORITY_ZERO = 12'h008;
  localparam logic [11:0] ADDR_RELOAD = 12'h00c;
  localparam logic [11:0] ADDR_COUNT = 12'h010;
  // ==========================================================
  // field positions
  localparam int ARM_BIT = 6;
  localparam int START_BIT = 6;
  localparam int EXPIRY_BIT = 6;
  localparam int PRESCALE_BIT = 7;
  // ==========================================================
  // reset values and counts
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] TERMINAL_COUNT = 16'h7cff;
  localparam int FLAG_LIFE_CYCLES = 12;
  localparam int MACHINE_DIV = 12;
  localparam int DIV2 = 2;
  localparam int DIV16 = 16;
endpackage : wdog_pkg

// [logic/tick_if.sv]
// Purpose: carries the prescaler tick and select between modules
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ns
interface tick_if;
  logic slow_sel;
  logic tick;
  modport src (input slow_sel, output tick);
  modport dst (output slow_sel, input tick);
endinterface : tick_if

// [logic/wdog_prescaler.sv]
// Purpose: divides the core clock to the watchdog count rate
// Assumes: runs only while the watchdog is active
// Notes: tick is one cycle wide every 24 or 384 clocks
`timescale 1ns/1ns
module wdog_prescaler
  import wdog_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  tick_if.src tk
);
  localparam int BASE = MACHINE_DIV * DIV2;
  localparam int LONG = BASE * DIV16;
  if (LONG > 1024 || BASE < 2)
  begin : g_bad_divide
    $error("prescaler divide out of counter range");
  end
  logic [9:0] cnt;
  logic [9:0] limit;
  // ==========================================================
  // divide chain: machine cycle, by 2, optional by 16
  assign limit = tk.slow_sel ? 10'(LONG - 1) : 10'(BASE - 1);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 10'h000;
    else if (!run || cnt >= limit)
      cnt <= 10'h000;
    else
      cnt <= cnt + 10'h001;
  end
  assign tk.tick = run && (cnt >= limit);
endmodule : wdog_prescaler

// [logic/wdog_top.sv]
// Purpose: software watchdog timer with apb register access
// Assumes: apb master per apb spec, one clock
// Notes: reset request is a level only while the count stays at 0x7cff
// Notes: read data is loaded in the setup cycle and stands in the access
// cycle, so pready stays high with no wait state
// Notes: the prescaler is not restarted by a refresh
// Notes on behaviour
// - 16-bit counter, step every 24/384 clocks
// - reset leaves watchdog off, registers zero
// - divide-by-2 and divide-by-16 prescaler stages
// - once started only reset stops it
// - writing start flag one starts counting
// - count 0x7cff raises expiry combinationally
// - expiry sets priority bit 6, requests reset
// - expiry clears on reset or leaving terminal
// - start within 12 cycles else no refresh
// - armed start while running reloads counter, clears arm
// - arm flag self-clears after 12 cycles
// - start flag self-clears after 12 cycles
// - reload bit 7 selects divide-by-16
// - reload bits 6-0 load counter high byte
// - reload register readable, writable anytime
`timescale 1ns/1ns
module wdog_top
  import wdog_pkg::*;
#(
  parameter int COUNT_WIDTH = 16,
  parameter int AGE_WIDTH = 4,
  parameter int FLAG_LIFE = FLAG_LIFE_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic expiry_status_signal,
  output logic reset_request
);
  import wdog_pkg::*;

  // ==========================================================
  // elaboration checks: the logic serves only these sizes
  if (COUNT_WIDTH != 16)
  begin : g_bad_count_width
    $error("watchdog count must be 16 bits wide");
  end
  if (AGE_WIDTH < 2 || AGE_WIDTH > 8)
  begin : g_bad_age_width
    $error("flag age counter width out of range");
  end
  if (FLAG_LIFE < 2 || FLAG_LIFE > (2 ** AGE_WIDTH))
  begin : g_bad_flag_life
    $error("flag life does not fit the age counter");
  end
  if (ARM_BIT > 7 || START_BIT > 7 || EXPIRY_BIT > 7)
  begin : g_bad_flag_bit
    $error("watchdog flag outside the low byte");
  end
  if (REG_RESET != 8'h00 || COUNT_RESET != 16'h0000)
  begin : g_bad_reset_value
    $error("watchdog must leave reset with all registers zero");
  end

  localparam logic [AGE_WIDTH-1:0] AGE_LAST = AGE_WIDTH'(FLAG_LIFE - 1);

  // ==========================================================
  // register and state
  logic [6:0] enable_zero_other;
  logic [6:0] enable_one_other;
  logic refresh_arm_flag;
  logic start_refresh_flag;
  logic [7:0] interrupt_enable_zero;
  logic [7:0] interrupt_enable_one;
  logic [7:0] priority_other;
  logic [7:0] reload_register;
  logic [COUNT_WIDTH-1:0] watchdog_count;
  logic running;
  logic [AGE_WIDTH-1:0] arm_age;
  logic [AGE_WIDTH-1:0] start_age;

  // ==========================================================
  // bus decode nets
  logic access;
  logic setup_rd;
  logic wr_en;
  logic mapped;
  logic sel_enable_zero;
  logic sel_enable_one;
  logic sel_priority;
  logic sel_reload;
  logic sel_count;
  logic wr_enable_zero;
  logic wr_enable_one;
  logic wr_priority;
  logic wr_reload;

  // ==========================================================
  // read values, one aligned word each
  logic [31:0] word_enable_zero;
  logic [31:0] word_enable_one;
  logic [31:0] word_priority;
  logic [31:0] word_reload;
  logic [31:0] word_count;
  logic [31:0] next_prdata;

  // ==========================================================
  // watchdog control nets
  logic arm_wr;
  logic start_wr;
  logic refresh;
  logic arm_expired;
  logic start_expired;
  logic at_terminal;

  // prescaler link
  tick_if tk ();

  // ==========================================================
  // apb handshake, zero wait states
  assign access = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_en = access && pwrite && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // ==========================================================
  // address decode; the count word is mapped, writes to it drop
  assign sel_enable_zero = (paddr == ADDR_ENABLE_ZERO);
  assign sel_enable_one = (paddr == ADDR_ENABLE_ONE);
  assign sel_priority = (paddr == ADDR_PRIORITY_ZERO);
  assign sel_reload = (paddr == ADDR_RELOAD);
  assign sel_count = (paddr == ADDR_COUNT);
  assign mapped = sel_enable_zero || sel_enable_one || sel_priority ||
                  sel_reload || sel_count;

  // ==========================================================
  // write strobes, byte lane 0 holds every register
  assign wr_enable_zero = wr_en && sel_enable_zero;
  assign wr_enable_one = wr_en && sel_enable_one;
  assign wr_priority = wr_en && sel_priority;
  assign wr_reload = wr_en && sel_reload;

  // ==========================================================
  // watchdog flag strobes
  assign arm_wr = wr_enable_zero && pwdata[ARM_BIT];
  assign start_wr = wr_enable_one && pwdata[START_BIT];
  assign arm_expired = refresh_arm_flag && (arm_age == AGE_LAST);
  assign start_expired = start_refresh_flag && (start_age == AGE_LAST);
  // a start counts as refresh only inside the armed window
  assign refresh = start_wr && refresh_arm_flag && running;

  // ==========================================================
  // refresh arm flag: a write wins over the self-clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      refresh_arm_flag <= REG_RESET[ARM_BIT];
    else if (wr_enable_zero)
      refresh_arm_flag <= pwdata[ARM_BIT];
    else if (refresh)
      refresh_arm_flag <= 1'b0;
    else if (arm_expired)
      refresh_arm_flag <= 1'b0;
  end

  // ==========================================================
  // interrupt enable zero, bits with no watchdog role
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_zero_other <= {REG_RESET[7], REG_RESET[5:0]};
    else if (wr_enable_zero)
      enable_zero_other <= {pwdata[7], pwdata[5:0]};
  end

  assign interrupt_enable_zero = {enable_zero_other[6], refresh_arm_flag,
                                  enable_zero_other[5:0]};

  // ==========================================================
  // arm flag age, restarted by every arming write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arm_age <= '0;
    else if (arm_wr || !refresh_arm_flag)
      arm_age <= '0;
    else
      arm_age <= arm_age + AGE_WIDTH'(1);
  end

  // ==========================================================
  // start/refresh flag: clearing it never stops the count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_refresh_flag <= REG_RESET[START_BIT];
    else if (wr_enable_one)
      start_refresh_flag <= pwdata[START_BIT];
    else if (start_expired)
      start_refresh_flag <= 1'b0;
  end

  // ==========================================================
  // interrupt enable one, bits with no watchdog role
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enable_one_other <= {REG_RESET[7], REG_RESET[5:0]};
    else if (wr_enable_one)
      enable_one_other <= {pwdata[7], pwdata[5:0]};
  end

  assign interrupt_enable_one = {enable_one_other[6], start_refresh_flag,
                                 enable_one_other[5:0]};

  // ==========================================================
  // start flag age, restarted by every start write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      start_age <= '0;
    else if (start_wr || !start_refresh_flag)
      start_age <= '0;
    else
      start_age <= start_age + AGE_WIDTH'(1);
  end

  // ==========================================================
  // priority register 0: bit 6 reads back as expiry status,
  // the stored copy of that bit is never read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      priority_other <= REG_RESET;
    else if (wr_priority)
      priority_other <= pwdata[7:0];
  end

  // ==========================================================
  // reload register, written and read at any time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_register <= REG_RESET;
    else if (wr_reload)
      reload_register <= pwdata[7:0];
  end

  // ==========================================================
  // run control: nothing but reset returns to idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      running <= 1'b0;
    else if (start_wr)
      running <= 1'b1;
  end

  // ==========================================================
  // prescaler: free running while active, so the first step after
  // a refresh comes within one prescaler period
  assign tk.slow_sel = reload_register[PRESCALE_BIT];

  wdog_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .tk(tk)
  );

  // ==========================================================
  // watchdog counter; a refresh wins over a step in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      watchdog_count <= COUNT_RESET;
    else if (refresh)
      watchdog_count <= {1'b0, reload_register[6:0], 8'h00};
    else if (tk.tick)
      watchdog_count <= watchdog_count + 16'h0001;
  end
  // the low byte is the zero field of the reload value above

  // ==========================================================
  // expiry: decoded from the count with no clock edge, a level
  // held while the count stays at the terminal value
  assign at_terminal = (watchdog_count == TERMINAL_COUNT);
  assign expiry_status_signal = running && at_terminal;
  assign reset_request = expiry_status_signal;

  // ==========================================================
  // read words, unused bits read as zero
  assign word_enable_zero = {24'h00_0000, interrupt_enable_zero};
  assign word_enable_one = {24'h00_0000, interrupt_enable_one};
  assign word_priority = {24'h00_0000, priority_other[7],
                          expiry_status_signal, priority_other[5:0]};
  assign word_reload = {24'h00_0000, reload_register};
  assign word_count = {16'h0000, watchdog_count};

  // ==========================================================
  // read select in the setup cycle; refused reads stay zero
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    if (setup_rd)
    begin
      unique case (paddr)
        ADDR_ENABLE_ZERO: next_prdata = word_enable_zero;
        ADDR_ENABLE_ONE: next_prdata = word_enable_one;
        ADDR_PRIORITY_ZERO: next_prdata = word_priority;
        ADDR_RELOAD: next_prdata = word_reload;
        ADDR_COUNT: next_prdata = word_count;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // read data flop: loaded in setup, stands through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= next_prdata;
  end

endmodule : wdog_top

// [sim/wdog_assertions.sv]
// Purpose: port checks for the watchdog top
// Assumes: one clock, apb zero wait
// Notes: bind at foot
`timescale 1ns/1ns
module wdog_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic expiry_status_signal,
  input wire logic reset_request
);
  logic rd;
  logic wr;
  logic [9:0] hi_len;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite && pstrb[0];
  // ==========================================================
  // expiry length counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hi_len <= 10'h0;
    else
      hi_len <= expiry_status_signal ? hi_len + 10'h1 : 10'h0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // properties
  property p_req; expiry_status_signal == reset_request; endproperty
  a_req: assert property (p_req) else $error("request differs");
  property p_ip; rd && paddr == 12'h008 |->
    prdata[6] == $past(expiry_status_signal); endproperty
  a_ip: assert property (p_ip) else $error("status bit wrong");
  property p_term; rd && paddr == 12'h010 |->
    $past(expiry_status_signal) == (prdata[15:0] == 16'h7cff); endproperty
  a_term: assert property (p_term) else $error("expiry wrong");
  property p_len; hi_len <= 10'd384; endproperty
  a_len: assert property (p_len) else $error("expiry too long");
  property p_rel; wr && paddr == 12'h00c ##2 rd && paddr == 12'h00c |->
    prdata[7:0] == $past(pwdata[7:0], 2); endproperty
  a_rel: assert property (p_rel) else $error("reload lost");
  property p_rst; $rose(presetn) |-> !expiry_status_signal; endproperty
  a_rst: assert property (p_rst) else $error("expiry after reset");
  property p_err; psel && penable && paddr > 12'h010 |->
    pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_hi; rd && paddr != 12'h010 |-> prdata[31:8] == 24'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
endmodule : wdog_checker
bind wdog_top wdog_checker i_wdog_checker (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .expiry_status_signal(expiry_status_signal),
  .reset_request(reset_request));

// [sim/tb_wdog_top.sv]
// Purpose: self-checking bench for the watchdog top
// Assumes: apb answers with pready
// Notes: full counts, no shortening
`timescale 1ns/1ns
module tb_wdog_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exp_s, req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  int miscompares, checks_done, cycles, n;
  wdog_top i_wdog_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .expiry_status_signal(exp_s), .reset_request(req));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      miscompares++;
      $display("wrong value at %0t: %h not %h", $time, seen, want);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = pslverr ? 32'hbad : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdchk(input logic [11:0] a, input logic [31:0] want);
    xfer(1'b0, a, 32'h0);
    check(rd, want);
  endtask : rdchk
  task automatic refresh(input logic [7:0] rel);
    xfer(1'b1, 12'h00c, {24'h0, rel});
    xfer(1'b1, 12'h000, 32'h40);
    xfer(1'b1, 12'h004, 32'h40);
  endtask : refresh
  task automatic t_start();
    // software watchdog driven by choice of this bench
    for (int a = 0; a <= 16; a += 4)
      rdchk(a[11:0], 32'h0);
    rdchk(12'h014, 32'hbad);
    xfer(1'b1, 12'h00c, 32'hff);
    rdchk(12'h00c, 32'hff);
    xfer(1'b1, 12'h00c, 32'h0);
    xfer(1'b1, 12'h004, 32'h40);
    rdchk(12'h004, 32'h40);
    repeat (12) @(posedge pclk);
    rdchk(12'h004, 32'h0);
    xfer(1'b1, 12'h004, 32'h0);
    repeat (110) @(posedge pclk);
    rdchk(12'h010, 32'h5);
    $display("start test done");
  endtask : t_start
  task automatic t_expire();
    refresh(8'h7c);
    xfer(1'b0, 12'h010, 32'h0);
    check({17'h0, rd[15:1]}, 32'h3e00);
    rdchk(12'h000, 32'h0);
    for (n = 0; n < 7000 && exp_s !== 1'b1; n++)
      @(posedge pclk);
    rdchk(12'h010, 32'h7cff);
    rdchk(12'h008, 32'h40);
    check({31'h0, req}, 32'h1);
    repeat (30) @(posedge pclk);
    rdchk(12'h008, 32'h0);
    $display("expiry test done");
  endtask : t_expire
  task automatic t_late();
    xfer(1'b1, 12'h000, 32'h40);
    repeat (12) @(posedge pclk);
    rdchk(12'h000, 32'h0);
    xfer(1'b1, 12'h004, 32'h40);
    xfer(1'b0, 12'h010, 32'h0);
    check({24'h0, rd[15:8]}, 32'h7d);
    refresh(8'hfc);
    repeat (200) @(posedge pclk);
    xfer(1'b0, 12'h010, 32'h0);
    check({17'h0, rd[15:1]}, 32'h3e00);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h010, 32'h0);
    rdchk(12'h00c, 32'h0);
    $display("late and slow test done");
  endtask : t_late
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_start();
    t_expire();
    t_late();
    stop_test();
  end
endmodule : tb_wdog_top
